// *** design/aip_packer.sv ***
// Analog input image packer with AXI4-Lite register access and interrupt
module aip_packer import aip_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Samples from the conversion logic, one per channel
  input aip_sample_s [NUM_CH-1:0] sample_i,
  // Register bus
  input aip_axi_req_s axi_req_i,
  output aip_axi_rsp_s axi_rsp_o,
  // Cyclic images toward the fieldbus side
  output aip_std_s [NUM_CH-1:0] std_img_o,
  output logic [NUM_CH-1:0][VALUE_W-1:0] cmp_img_o,
  output logic [NUM_CH-1:0] std_en_o,
  output logic [NUM_CH-1:0] cmp_en_o,
  // Interrupt
  output logic irq_o
);

  aip_std_s [NUM_CH-1:0] std_q;
  logic [NUM_CH-1:0][VALUE_W-1:0] cmp_q;
  logic [2*NUM_CH-1:0] sel_q;
  logic [2*NUM_CH-1:0] sel_wr;
  logic [2*NUM_CH-1:0] sel_merged;
  logic [31:0] mask_q;
  logic [31:0] stat_q;
  logic [31:0] stat_set;
  logic [31:0] stat_clr;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] wr_mask;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] rd_idx;

  // Image packing per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        std_q[c] <= '0;
      end else if (sample_i[c].valid) begin
        std_q[c].underrange <= sample_i[c].underrange; // [RQ1]
        std_q[c].overrange <= sample_i[c].overrange; // [RQ2]
        std_q[c].limit1 <= sample_i[c].limit1; // [RQ3]
        std_q[c].limit2 <= sample_i[c].limit2; // [RQ4]
        std_q[c].pad2 <= '0; // [RQ5]
        std_q[c].pad6 <= '0; // [RQ5]
        std_q[c].data_invalid_flag <= sample_i[c].acq_err; // [RQ6] [RQ9]
        std_q[c].update_toggle_bit <= ~std_q[c].update_toggle_bit; // [RQ7] [RQ10]
        std_q[c].value <= sample_i[c].value; // [RQ8] [RQ14]
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cmp_q[c] <= '0;
      end else if (sample_i[c].valid) begin
        cmp_q[c] <= sample_i[c].value; // [RQ13]
      end
    end

    // Event bits: new sample in 7:0, failed acquisition in 15:8
    assign stat_set[c] = sample_i[c].valid;
    assign stat_set[NUM_CH+c] = sample_i[c].valid & sample_i[c].acq_err;

    // A write that selects both images of a channel keeps that channel as it was
    assign sel_wr[2*c+:2] = (&sel_merged[2*c+:2]) ? sel_q[2*c+:2] : sel_merged[2*c+:2]; // [RQ11]
  end
  assign stat_set[31:2*NUM_CH] = '0;

  // Kept as a net so each channel's pick follows every change of the bus and the register
  assign sel_merged = (sel_q & ~wr_mask[2*NUM_CH-1:0])
    | (axi_req_i.wdata[2*NUM_CH-1:0] & wr_mask[2*NUM_CH-1:0]);

  assign std_img_o = std_q;
  assign cmp_img_o = cmp_q;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_en
    assign std_en_o[c] = sel_q[2*c];
    assign cmp_en_o[c] = sel_q[2*c+1];
  end

  // Write path: address and data are taken together in one beat
  assign wr_fire = axi_req_i.awvalid & axi_req_i.wvalid & ~bvalid_q;
  assign wr_hit = (axi_req_i.awaddr == SEL_OFFS) || (axi_req_i.awaddr == IRQ_MASK_OFFS);

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wr_mask[8*b+:8] = {8{axi_req_i.wstrb[b]}};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q <= SEL_RST[2*NUM_CH-1:0];
    end else if (wr_fire && axi_req_i.awaddr == SEL_OFFS) begin
      sel_q <= sel_wr; // [RQ11]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_q <= MASK_RST;
    end else if (wr_fire && axi_req_i.awaddr == IRQ_MASK_OFFS) begin
      mask_q <= (mask_q & ~wr_mask) | (axi_req_i.wdata & wr_mask);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_i.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read path
  assign rd_fire = axi_req_i.arvalid & ~rvalid_q;
  assign rd_idx = {5'h00, axi_req_i.araddr[4:2]};

  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    if (axi_req_i.araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (axi_req_i.araddr == SEL_OFFS) begin
      rd_data[2*NUM_CH-1:0] = sel_q;
    end else if (axi_req_i.araddr == IRQ_STAT_OFFS) begin
      rd_data = stat_q;
    end else if (axi_req_i.araddr == IRQ_MASK_OFFS) begin
      rd_data = mask_q;
    end else if (axi_req_i.araddr[7:5] == EXCL_BASE[7:5]) begin
      // Standard image excludes its compact twin and the other way round
      rd_data[7:0] = IMG_FIRST + 8'(rd_idx << 1) + 8'h01; // [RQ11] [RQ12]
      rd_data[15:8] = IMG_FIRST + 8'(rd_idx << 1); // [RQ12]
    end else if (axi_req_i.araddr[7:5] == STD_BASE[7:5]) begin
      rd_data = std_q[rd_idx[2:0]];
    end else if (axi_req_i.araddr[7:5] == CMP_BASE[7:5]) begin
      rd_data[VALUE_W-1:0] = cmp_q[rd_idx[2:0]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_i.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Read of the status register clears what it returned; a new event wins
  assign stat_clr = (rd_fire && axi_req_i.araddr == IRQ_STAT_OFFS) ? stat_q : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  always_comb begin
    axi_rsp_o = '0;
    axi_rsp_o.awready = wr_fire;
    axi_rsp_o.wready = wr_fire;
    axi_rsp_o.bvalid = bvalid_q;
    axi_rsp_o.bresp = bresp_q;
    axi_rsp_o.arready = ~rvalid_q;
    axi_rsp_o.rvalid = rvalid_q;
    axi_rsp_o.rdata = rdata_q;
    axi_rsp_o.rresp = rresp_q;
  end

  // Checks on the first and last channel, a_excl_read on channel seven, and a_excl_all over every channel; the others share the generated logic
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_sample;
    sample_i[0].valid;
  endsequence

  sequence s_quiet2;
    !sample_i[0].valid [*2];
  endsequence

  sequence s_sample7;
    sample_i[NUM_CH-1].valid;
  endsequence

  property p_under;
    s_sample |=> std_img_o[0].underrange == $past(sample_i[0].underrange);
  endproperty
  a_under: assert property (p_under) else $error("underrange bit wrong"); // [RQ1]

  property p_over;
    s_sample |=> std_img_o[0].overrange == $past(sample_i[0].overrange);
  endproperty
  a_over: assert property (p_over) else $error("overrange bit wrong"); // [RQ2]

  property p_limits;
    s_sample |=> std_img_o[0].limit1 == $past(sample_i[0].limit1)
      && std_img_o[0].limit2 == $past(sample_i[0].limit2);
  endproperty
  a_limits: assert property (p_limits) else $error("limit fields wrong"); // [RQ3] [RQ4]

  property p_pad;
    std_img_o[0][13:6] == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("padding bits not zero"); // [RQ5]

  property p_invalid;
    s_sample ##0 sample_i[0].acq_err ##1 s_quiet2 |=> std_img_o[0][14];
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid flag lost"); // [RQ6] [RQ9]

  property p_valid_clear;
    s_sample ##0 !sample_i[0].acq_err |=> !std_img_o[0].data_invalid_flag;
  endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("invalid flag stuck"); // [RQ9]

  property p_toggle;
    s_sample |=> std_img_o[0][15] != $past(std_img_o[0][15]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip"); // [RQ7] [RQ10]

  property p_toggle_hold;
    !sample_i[0].valid |=> $stable(std_img_o[0].update_toggle_bit);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle flipped idle"); // [RQ10]

  property p_value;
    s_sample |=> std_img_o[0][31:16] == $past(sample_i[0].value)
      && cmp_img_o[0] == std_img_o[0][31:16];
  endproperty
  a_value: assert property (p_value) else $error("value field wrong"); // [RQ8] [RQ13] [RQ14]

  property p_excl;
    !(std_en_o[0] && cmp_en_o[0]) && !(std_en_o[NUM_CH-1] && cmp_en_o[NUM_CH-1]);
  endproperty
  a_excl: assert property (p_excl) else $error("both images enabled"); // [RQ11]

  property p_irq_clear;
    rd_fire && axi_req_i.araddr == IRQ_STAT_OFFS && !sample_i[0].valid |=> !stat_q[0];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status not cleared"); // [RQ10]

  property p_excl_read;
    rd_fire && axi_req_i.araddr == EXCL_BASE + 8'h18 |=> rvalid_q && rdata_q[15:0] == 16'h0D0E;
  endproperty
  a_excl_read: assert property (p_excl_read) else $error("channel seven images wrong"); // [RQ12]

  property p_flags7;
    s_sample7 |=> std_img_o[NUM_CH-1][5:0] == $past({sample_i[NUM_CH-1].limit2,
      sample_i[NUM_CH-1].limit1, sample_i[NUM_CH-1].overrange, sample_i[NUM_CH-1].underrange});
  endproperty
  a_flags7: assert property (p_flags7) else $error("top flags wrong"); // [RQ1] [RQ2] [RQ3] [RQ4]

  property p_value7;
    s_sample7 |=> std_img_o[NUM_CH-1].value == $past(sample_i[NUM_CH-1].value)
      && cmp_img_o[NUM_CH-1] == $past(sample_i[NUM_CH-1].value);
  endproperty
  a_value7: assert property (p_value7) else $error("top value wrong"); // [RQ8] [RQ13]

  property p_toggle7;
    s_sample7 |=> std_img_o[NUM_CH-1].update_toggle_bit
      != $past(std_img_o[NUM_CH-1].update_toggle_bit);
  endproperty
  a_toggle7: assert property (p_toggle7) else $error("top toggle stuck"); // [RQ7] [RQ10]

  property p_invalid7;
    s_sample7 |=> std_img_o[NUM_CH-1].data_invalid_flag == $past(sample_i[NUM_CH-1].acq_err);
  endproperty
  a_invalid7: assert property (p_invalid7) else $error("top invalid flag wrong"); // [RQ6] [RQ9]

  property p_hold;
    !sample_i[0].valid |=> $stable(std_img_o[0]) && $stable(cmp_img_o[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("image changed without a sample"); // [RQ8] [RQ13]

  property p_excl_all;
    (std_en_o & cmp_en_o) == '0;
  endproperty
  a_excl_all: assert property (p_excl_all) else $error("a channel has both images"); // [RQ11]

  property p_excl_ro;
    wr_fire && axi_req_i.awaddr[7:5] == EXCL_BASE[7:5] |=> bvalid_q && bresp_q == RESP_SLVERR;
  endproperty
  a_excl_ro: assert property (p_excl_ro) else $error("exclusion list writable"); // [RQ11]

  property p_sel_keep;
    wr_fire && axi_req_i.awaddr == SEL_OFFS && axi_req_i.wstrb[0]
      && axi_req_i.wdata[1:0] == 2'h3 |=> std_en_o[0] == $past(std_en_o[0])
      && cmp_en_o[0] == $past(cmp_en_o[0]);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("double select not ignored"); // [RQ11]

  property p_excl_read8;
    rd_fire && axi_req_i.araddr == EXCL_BASE + 8'h1c |=> rvalid_q && rdata_q[15:0] == 16'h0F10;
  endproperty
  a_excl_read8: assert property (p_excl_read8) else $error("channel eight numbers"); // [RQ12]

  property p_excl_read1;
    rd_fire && axi_req_i.araddr == EXCL_BASE |=> rvalid_q && rdata_q[15:0] == 16'h0102;
  endproperty
  a_excl_read1: assert property (p_excl_read1) else $error("channel one numbers"); // [RQ12]

  property p_stat_new;
    s_sample |=> stat_q[0];
  endproperty
  a_stat_new: assert property (p_stat_new) else $error("new sample not flagged"); // [RQ10]

  property p_stat_err;
    s_sample ##0 sample_i[0].acq_err |=> stat_q[NUM_CH];
  endproperty
  a_stat_err: assert property (p_stat_err) else $error("failed sample not flagged"); // [RQ9]

  property p_b_after_w;
    wr_fire |=> axi_rsp_o.bvalid && !axi_rsp_o.awready;
  endproperty
  a_b_after_w: assert property (p_b_after_w) else $error("write not answered");

  property p_r_after_a;
    rd_fire |=> axi_rsp_o.rvalid && !axi_rsp_o.arready;
  endproperty
  a_r_after_a: assert property (p_r_after_a) else $error("read not answered");

  property p_b_drop;
    bvalid_q && axi_req_i.bready |=> !bvalid_q;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response stuck");

  property p_r_drop;
    rvalid_q && axi_req_i.rready |=> !rvalid_q;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read response stuck");

  property p_rd_err_zero;
    rvalid_q && rresp_q == RESP_SLVERR |-> rdata_q == 32'h0000_0000;
  endproperty
  a_rd_err_zero: assert property (p_rd_err_zero) else $error("refused read returned data");

endmodule

// *** design/aip_pkg.sv ***
// Constants, register map and carrier types of the analog input image packer
// Overview of operation
// RQ1 - Bit 0 of the standard word is the channel's underrange flag.
// RQ2 - Bit 1 of the standard word is the overrange flag, right after underrange.
// RQ3 - Bits 3:2 of the standard word hold the first limit comparison result.
// RQ4 - Bits 5:4 of the standard word hold the second limit comparison result.
// RQ5 - Two then six padding bits follow the limit fields and always read as zero.
// RQ6 - Bit 14 of the standard word is the data-invalid flag, after the padding.
// RQ7 - Bit 15 of the standard word is the update toggle, right after the invalid flag.
// RQ8 - Bits 31:16 hold the 16-bit measured value, the ninth and last entry.
// RQ9 - The data-invalid flag is set when a sample could not be acquired and cleared otherwise.
// RQ10 - The update toggle inverts each time fresh data is written into the image.
// RQ11 - Standard and compact images of a channel are never enabled together; list is read-only.
// RQ12 - Channel c owns image numbers 2c+1 (standard) and 2c+2 (compact), 13/14 and 15/16 for 7/8.
// RQ13 - The compact image holds only the 16-bit measured value.
// RQ14 - Standard entries pack from bit 0 upward into exactly one 32-bit word per channel.
package aip_pkg;

  localparam int NUM_CH = 8;
  localparam int VALUE_W = 16;

  // Register byte addresses
  localparam logic [7:0] SEL_OFFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h08;
  localparam logic [7:0] EXCL_BASE = 8'h20;
  localparam logic [7:0] STD_BASE = 8'h40;
  localparam logic [7:0] CMP_BASE = 8'h60;

  // Reset values
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // Image numbering: standard image of channel c is IMG_FIRST + 2c
  localparam logic [7:0] IMG_FIRST = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Standard image, packed from bit 0 upward
  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic update_toggle_bit;
    logic data_invalid_flag;
    logic [5:0] pad6;
    logic [1:0] pad2;
    logic [1:0] limit2;
    logic [1:0] limit1;
    logic overrange;
    logic underrange;
  } aip_std_s;

  // One sample from the conversion logic
  typedef struct packed {
    logic valid;
    logic acq_err;
    logic underrange;
    logic overrange;
    logic [1:0] limit1;
    logic [1:0] limit2;
    logic [VALUE_W-1:0] value;
  } aip_sample_s;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } aip_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aip_axi_rsp_s;

endpackage

// *** sim/aip_fb_master.sv ***
// Fieldbus master model capturing the selected image of each channel every cycle
module aip_fb_master import aip_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Images and their selects
  input aip_std_s [NUM_CH-1:0] std_img,
  input logic [NUM_CH-1:0][VALUE_W-1:0] cmp_img,
  input logic [NUM_CH-1:0] std_en,
  input logic [NUM_CH-1:0] cmp_en,
  // Captured words and selection conflict
  output logic [NUM_CH-1:0][31:0] cap_q,
  output logic clash_q
);
  // Standard wins when both are set so a clash still shows a defined word
  always_ff @(posedge core_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      cap_q[c] <= std_en[c] ? 32'(std_img[c]) : {16'h0000, cmp_img[c]};
    end
    clash_q <= |(std_en & cmp_en);
  end
endmodule

// *** sim/analog_input_pdo_packer_tb_top.sv ***
// Self-checking bench of the analog input image packer
module analog_input_pdo_packer_tb_top import aip_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  aip_sample_s [NUM_CH-1:0] smp = '0;
  aip_axi_req_s req = '0;
  aip_axi_rsp_s rsp;
  aip_std_s [NUM_CH-1:0] std_img;
  logic [NUM_CH-1:0][VALUE_W-1:0] cmp_img;
  logic [NUM_CH-1:0] std_en;
  logic [NUM_CH-1:0] cmp_en;
  logic irq;
  logic [NUM_CH-1:0][31:0] cap;
  logic clash;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int m_stat = 0;
  logic [31:0] m_std [NUM_CH];

  always #25 core_clk = ~core_clk;

  aip_packer dut_u (.core_clk(core_clk), .rst(rst), .sample_i(smp), .axi_req_i(req),
    .axi_rsp_o(rsp), .std_img_o(std_img), .cmp_img_o(cmp_img), .std_en_o(std_en),
    .cmp_en_o(cmp_en), .irq_o(irq));

  aip_fb_master fbm_u (.core_clk(core_clk), .std_img(std_img), .cmp_img(cmp_img),
    .std_en(std_en), .cmp_en(cmp_en), .cap_q(cap), .clash_q(clash));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang anywhere ends here; the full run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
    input logic [3:0] st = 4'hf);
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= st;
    req.bready <= 1'b1;
    do @(posedge core_clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge core_clk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", 32'(rsp.bresp), 32'(er));
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge core_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge core_clk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk("rdata", rsp.rdata, exp);
    chk("rresp", 32'(rsp.rresp), 32'(er));
  endtask

  // One random sample into channel c; the model flips its own copy of the toggle
  task automatic put(input int c, input logic err);
    aip_sample_s s;
    logic [31:0] w;
    s = aip_sample_s'(24'($urandom));
    s.valid = 1'b1;
    s.acq_err = err;
    @(posedge core_clk);
    smp[c] <= s;
    @(posedge core_clk);
    smp[c].valid <= 1'b0;
    w = {s.value, ~m_std[c][15], err, 8'h00, s.limit2, s.limit1, s.overrange, s.underrange};
    m_std[c] = w;
    m_stat = m_stat | (1 << c) | (err ? (1 << (8 + c)) : 0);
    #1;
    chk("std_flags", 32'(std_img[c][15:0]), 32'(w[15:0]));
    chk("std_img", std_img[c], w);
    chk("cmp_img", 32'(cmp_img[c]), 32'(s.value));
  endtask

  initial begin
    void'($urandom(32'hd29f));
    for (int c = 0; c < NUM_CH; c++) begin
      m_std[c] = 32'h0000_0000;
    end
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rdr(SEL_OFFS, SEL_RST, RESP_OKAY);
    rdr(IRQ_MASK_OFFS, MASK_RST, RESP_OKAY);
    for (int c = 0; c < NUM_CH; c++) begin
      rdr(EXCL_BASE + 8'(4 * c), {16'h0000, IMG_FIRST + 8'(2 * c), IMG_FIRST + 8'(2 * c + 1)},
        RESP_OKAY);
    end
    wr(EXCL_BASE + 8'h18, 32'hffff_ffff, RESP_SLVERR);
    rdr(EXCL_BASE + 8'h18, 32'h0000_0d0e, RESP_OKAY);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        put(c, 1'(r ^ c));
      end
      for (int c = 0; c < NUM_CH; c++) begin
        rdr(STD_BASE + 8'(4 * c), m_std[c], RESP_OKAY);
        rdr(CMP_BASE + 8'(4 * c), {16'h0000, m_std[c][31:16]}, RESP_OKAY);
      end
    end
    chk("irq", 32'(irq), 32'h0000_0000);
    rdr(IRQ_STAT_OFFS, 32'(m_stat), RESP_OKAY);
    m_stat = 0;
    rdr(IRQ_STAT_OFFS, 32'h0000_0000, RESP_OKAY);
    // Only the acquisition-failed bit of channel 0 may raise the line
    wr(IRQ_MASK_OFFS, 32'h0000_0100, RESP_OKAY);
    put(0, 1'b0);
    chk("irq", 32'(irq), 32'h0000_0000);
    put(0, 1'b1);
    chk("irq", 32'(irq), 32'h0000_0001);
    rdr(IRQ_STAT_OFFS, 32'(m_stat), RESP_OKAY);
    #1;
    chk("irq", 32'(irq), 32'h0000_0000);
    // Only byte lane 1 of the mask may change
    wr(IRQ_MASK_OFFS, 32'hffff_ffff, RESP_OKAY, 4'h2);
    rdr(IRQ_MASK_OFFS, 32'h0000_ff00, RESP_OKAY);
    wr(SEL_OFFS, 32'h0000_0003, RESP_OKAY);
    rdr(SEL_OFFS, 32'h0000_0000, RESP_OKAY);
    wr(SEL_OFFS, 32'h0000_0009, RESP_OKAY);
    wr(SEL_OFFS, 32'h0000_000d, RESP_OKAY);
    rdr(SEL_OFFS, 32'h0000_0009, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    #1;
    chk("std_en", 32'(std_en), 32'h0000_0001);
    chk("cmp_en", 32'(cmp_en), 32'h0000_0002);
    chk("cap0", cap[0], m_std[0]);
    chk("cap1", cap[1], {16'h0000, m_std[1][31:16]});
    chk("clash", 32'(clash), 32'h0000_0000);
    rdr(8'h1c, 32'h0000_0000, RESP_SLVERR);
    wr(8'h1c, 32'h1234_5678, RESP_SLVERR);
    tally_and_finish();
  end
endmodule
